// ===== rtl/capture_compare_channel.sv
// Purpose: Four capture/compare channels on two unit timers
// Assumes: Plain register port, reads answered one cycle later
// Notes:   Pins pass a two-stage synchroniser before edge detect
//
// Overview of operation
// R01: Select bit picks first timer when clear, second timer when set.
// R02: Four 3-bit mode fields at 14:12, 10:8, 6:4, 2:0.
// R03: Mode 000 makes the value register plain storage, no events.
// R04: Modes 001, 010, 011 capture on rising, falling, either edge.
// R05: Mode 100 raises only the request on every match.
// R06: Mode 101 toggles the pin and raises the request each match.
// R07: Mode 110 raises one request per period, pin untouched.
// R08: Mode 111 sets pin on first match, clears it on overflow.
// R09: Paired compare allowed for bank-two mode 100, bank-one mode 101.
// R10: Events on the last channel may trigger a converter injection.
// R11: Capture copies the allocated timer and raises the request.
// R12: Outside keeps capture pins as inputs, levels held stable long enough.
// R13: Compare checks value against its timer, raises request on match.
// R14: Modes 100 and 110 never change the pin.
// R15: Only exact equality matches; a passed value waits for next period.
// R16: Compare evaluated only in the cycle after a hardware increment.
// R17: Software writing the timer to the value gives no match.
// R18: Shared values all fire once, then wait for the next increment.
// R19: No compare events after reset until timer increments.
// R20: Staggered mode fires matching channels one after another.
// R21: Mode register fully read/write, resets to zero.
// R22: Modes 110 and 111 block further matches until overflow.
// R23: Mode 111 set and overflow in one cycle leave pin unchanged.
// R24: Timer reloads from its reload register on overflow.
// R25: Each request is a single-cycle pulse per event.
`timescale 1ns/1ps
`default_nettype none
module capture_compare_channel #(
	parameter int unsigned PRESCALE = 1,
	parameter bit BANK_HI = 1'b1
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic [3:0] channel_pin_i,
	output logic [3:0] channel_pin_o,
	output logic [3:0] channel_pin_oe,
	output logic [3:0] channel_interrupt_request,
	output logic adc_trigger
);
	localparam int PRE_W = 14;
	localparam int NT = 2;
	localparam logic [PRE_W-1:0] LIM_N = PRE_W'(PRESCALE - 1);
	localparam logic [PRE_W-1:0] LIM_S =
		PRE_W'(PRESCALE * ccc_pkg::STAG_MULT - 1);

	logic [15:0] channel_mode_control_7_q;
	logic [3:0] ctrl_q;
	logic [15:0] tmr_q [NT];
	logic [15:0] rel_q [NT];
	logic [PRE_W-1:0] pre_q [NT];
	logic [NT-1:0] tick;
	logic [NT-1:0] tmr_wr;
	logic [NT-1:0] inc_q;
	logic [NT-1:0] ovf_q;
	logic [2:0] inc_sr_q [NT];
	logic [2:0] ovf_sr_q [NT];
	logic [3:0] go_stage [NT];
	logic [3:0] ovf_stage [NT];
	logic [3:0] pin_s1_q;
	logic [3:0] pin_s2_q;
	logic [3:0] pin_s3_q;
	logic [3:0] rise;
	logic [3:0] fall;
	logic [2:0] mode [ccc_pkg::NCH];
	logic [ccc_pkg::NCH-1:0] tsel;
	logic [ccc_pkg::NCH-1:0] go_ch;
	logic [ccc_pkg::NCH-1:0] ovf_ch;
	logic [ccc_pkg::NCH-1:0] val_wr;
	logic [ccc_pkg::NCH-1:0] evt;
	logic [ccc_pkg::NCH-1:0] dbl_ok;
	logic [15:0] chan_tmr [ccc_pkg::NCH];
	logic [15:0] chan_val [ccc_pkg::NCH];
	logic [15:0] rd_mux;
	logic stag;

	assign stag = ctrl_q[ccc_pkg::CTRL_STAG];

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			channel_mode_control_7_q <= ccc_pkg::MODE_RST; // R21
		end else if (wr && (addr == ccc_pkg::ADDR_MODE)) begin
			channel_mode_control_7_q <= wdata; // R21
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= ccc_pkg::CTRL_RST;
		end else if (wr && (addr == ccc_pkg::ADDR_CTRL)) begin
			ctrl_q <= wdata[3:0];
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rel_q[0] <= ccc_pkg::WORD_ZERO;
			rel_q[1] <= ccc_pkg::WORD_ZERO;
		end else if (wr && (addr == ccc_pkg::ADDR_REL0)) begin
			rel_q[0] <= wdata;
		end else if (wr && (addr == ccc_pkg::ADDR_REL1)) begin
			rel_q[1] <= wdata;
		end
	end

	assign tmr_wr[0] = wr && (addr == ccc_pkg::ADDR_TMR0);
	assign tmr_wr[1] = wr && (addr == ccc_pkg::ADDR_TMR1);

	// ------------------------------------------------------------
	// Unit timers
	// ------------------------------------------------------------
	always_comb begin
		for (int t = 0; t < NT; t++) begin
			tick[t] = ctrl_q[t] && (pre_q[t] == (stag ? LIM_S : LIM_N));
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int t = 0; t < NT; t++) begin
				pre_q[t] <= '0;
			end
		end else begin
			for (int t = 0; t < NT; t++) begin
				if (!ctrl_q[t] || tick[t]) begin
					pre_q[t] <= '0;
				end else begin
					pre_q[t] <= pre_q[t] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int t = 0; t < NT; t++) begin
				tmr_q[t] <= ccc_pkg::WORD_ZERO;
			end
		end else begin
			for (int t = 0; t < NT; t++) begin
				if (tmr_wr[t]) begin
					tmr_q[t] <= wdata; // R17
				end else if (tick[t]) begin
					if (tmr_q[t] == ccc_pkg::TMR_MAX) begin
						tmr_q[t] <= rel_q[t]; // R24
					end else begin
						tmr_q[t] <= tmr_q[t] + 1'b1;
					end
				end
			end
		end
	end

	// Compare strobe in the cycle after a hardware increment only
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			inc_q <= '0;
			ovf_q <= '0;
		end else begin
			for (int t = 0; t < NT; t++) begin
				inc_q[t] <= tick[t] && !tmr_wr[t]; // R16 R17 R19
				ovf_q[t] <= tick[t] && !tmr_wr[t] &&
					(tmr_q[t] == ccc_pkg::TMR_MAX);
			end
		end
	end

	// Staggered slots: channel k sees the strobe k cycles late
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int t = 0; t < NT; t++) begin
				inc_sr_q[t] <= '0;
				ovf_sr_q[t] <= '0;
			end
		end else begin
			for (int t = 0; t < NT; t++) begin
				inc_sr_q[t] <= {inc_sr_q[t][1:0], inc_q[t]}; // R20
				ovf_sr_q[t] <= {ovf_sr_q[t][1:0], ovf_q[t]};
			end
		end
	end

	always_comb begin
		for (int t = 0; t < NT; t++) begin
			go_stage[t] = {inc_sr_q[t], inc_q[t]};
			ovf_stage[t] = {ovf_sr_q[t], ovf_q[t]};
		end
	end

	// ------------------------------------------------------------
	// Pin synchroniser and edge detect
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
		end else begin
			pin_s1_q <= channel_pin_i; // R12
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	assign rise = pin_s2_q & ~pin_s3_q;
	assign fall = ~pin_s2_q & pin_s3_q;

	// ------------------------------------------------------------
	// Channel field decode and timer routing
	// ------------------------------------------------------------
	always_comb begin
		for (int k = 0; k < ccc_pkg::NCH; k++) begin
			mode[k] = channel_mode_control_7_q[k*ccc_pkg::FLD_W +:
				ccc_pkg::MODE_W]; // R02
			tsel[k] = channel_mode_control_7_q[k*ccc_pkg::FLD_W +
				ccc_pkg::SEL_POS]; // R01
			chan_tmr[k] = tmr_q[tsel[k]]; // R01
			go_ch[k] = go_stage[tsel[k]][stag ? k : 0]; // R18 R20
			ovf_ch[k] = ovf_stage[tsel[k]][stag ? k : 0];
			val_wr[k] = wr && (addr == ccc_pkg::ADDR_VAL0 +
				16'(k) * ccc_pkg::ADDR_STEP);
			dbl_ok[k] = ((mode[k] == ccc_pkg::CMP_IRQ) && BANK_HI) ||
				((mode[k] == ccc_pkg::CMP_TOG) && !BANK_HI); // R09
		end
	end

	for (genvar k = 0; k < ccc_pkg::NCH; k++) begin : g_chan
		ccc_chan u_chan (
			.sys_clk(sys_clk),
			.reset(reset),
			.mode(mode[k]),
			.tmr(chan_tmr[k]),
			.go(go_ch[k]),
			.ovf(ovf_ch[k]),
			.rise(rise[k]),
			.fall(fall[k]),
			.wr_en(val_wr[k]),
			.wr_data(wdata),
			.evt(evt[k]),
			.val_q(chan_val[k]),
			.irq_q(channel_interrupt_request[k]),
			.pin_q(channel_pin_o[k]),
			.oe_q(channel_pin_oe[k])
		);
	end

	// ------------------------------------------------------------
	// Converter trigger from the last channel
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			adc_trigger <= 1'b0;
		end else begin
			adc_trigger <= evt[ccc_pkg::NCH-1] &&
				ctrl_q[ccc_pkg::CTRL_ADC]; // R10
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	always_comb begin
		rd_mux = ccc_pkg::WORD_ZERO;
		unique case (addr)
			ccc_pkg::ADDR_MODE: rd_mux = channel_mode_control_7_q; // R21
			ccc_pkg::ADDR_TMR0: rd_mux = tmr_q[0];
			ccc_pkg::ADDR_TMR1: rd_mux = tmr_q[1];
			ccc_pkg::ADDR_REL0: rd_mux = rel_q[0];
			ccc_pkg::ADDR_REL1: rd_mux = rel_q[1];
			ccc_pkg::ADDR_CTRL: rd_mux = {12'h000, ctrl_q};
			ccc_pkg::ADDR_STAT:
				rd_mux = {4'h0, pin_s2_q, dbl_ok, channel_pin_o};
			default: begin
				for (int k = 0; k < ccc_pkg::NCH; k++) begin
					if (addr == ccc_pkg::ADDR_VAL0 +
						16'(k) * ccc_pkg::ADDR_STEP) begin
						rd_mux = chan_val[k];
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rdata <= ccc_pkg::WORD_ZERO;
		end else begin
			rdata <= rd ? rd_mux : ccc_pkg::WORD_ZERO;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_mode_rw;
		wr && (addr == ccc_pkg::ADDR_MODE) ##1 rd &&
			(addr == ccc_pkg::ADDR_MODE) |=> rdata == $past(wdata, 2);
	endproperty
	a_mode_rw: assert property (p_mode_rw) // R21
		else $error("mode register readback mismatch");

	property p_reload;
		tick[0] && !tmr_wr[0] && (tmr_q[0] == ccc_pkg::TMR_MAX) |=>
			tmr_q[0] == $past(rel_q[0]);
	endproperty
	a_reload: assert property (p_reload) // R24
		else $error("timer did not reload on overflow");

	property p_sw_write_no_strobe;
		tmr_wr[0] |=> !inc_q[0];
	endproperty
	a_sw_write_no_strobe: assert property (p_sw_write_no_strobe) // R17
		else $error("software timer write produced a compare strobe");

	property p_disabled_quiet;
		$past(mode[0]) == ccc_pkg::MODE_OFF |-> !channel_interrupt_request[0];
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) // R03
		else $error("disabled channel raised a request");

	property p_irq_only_pin;
		(mode[1] == ccc_pkg::CMP_IRQ) || (mode[1] == ccc_pkg::CMP_ONCE) |=>
			$stable(channel_pin_o[1]);
	endproperty
	a_irq_only_pin: assert property (p_irq_only_pin) // R14
		else $error("interrupt-only mode changed the pin");

	property p_toggle;
		channel_interrupt_request[0] && $past(mode[0]) == ccc_pkg::CMP_TOG |->
			channel_pin_o[0] != $past(channel_pin_o[0]);
	endproperty
	a_toggle: assert property (p_toggle) // R06
		else $error("toggle mode match did not invert the pin");

	property p_adc;
		channel_interrupt_request[3] && $past(ctrl_q[ccc_pkg::CTRL_ADC]) |->
			adc_trigger;
	endproperty
	a_adc: assert property (p_adc) // R10
		else $error("last channel event did not trigger converter");

	property p_cmp_strobe;
		channel_interrupt_request[2] && $past(mode[2][2]) |->
			$past(go_ch[2]) && $past(chan_tmr[2] == chan_val[2]);
	endproperty
	a_cmp_strobe: assert property (p_cmp_strobe) // R13 R15 R16
		else $error("compare request without strobe and equality");

	property p_capture;
		channel_interrupt_request[1] && $past(mode[1]) == ccc_pkg::CAP_RISE
			|-> chan_val[1] == $past(chan_tmr[1]) && $past(rise[1]);
	endproperty
	a_capture: assert property (p_capture) // R04 R11
		else $error("capture did not latch the timer");

	property p_set_cancel;
		mode[0] == ccc_pkg::CMP_SET && go_ch[0] && ovf_ch[0] &&
			chan_tmr[0] == chan_val[0] |=> $stable(channel_pin_o[0]);
	endproperty
	a_set_cancel: assert property (p_set_cancel) // R23
		else $error("set and overflow together changed the pin");

	property p_pulse;
		inc_q[0] && (stag || (PRESCALE > 1)) |=> !inc_q[0];
	endproperty
	a_pulse: assert property (p_pulse) // R16 R25
		else $error("compare strobe longer than one cycle");

	c_capture: cover property (channel_interrupt_request[1] &&
		$past(mode[1]) == ccc_pkg::CAP_BOTH);
	c_toggle: cover property (channel_interrupt_request[0] &&
		$past(mode[0]) == ccc_pkg::CMP_TOG);
	c_stagger: cover property (stag && go_ch[3]);
	c_adc: cover property (adc_trigger);
endmodule // capture_compare_channel
`default_nettype wire

// ===== rtl/ccc_chan.sv
// Purpose: One capture/compare channel: value, event, pin output
// Assumes: go/ovf already selected for this channel's timer
// Notes:   Capture wins over a software write in the same cycle
`timescale 1ns/1ps
`default_nettype none
module ccc_chan (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [2:0] mode,
	input wire logic [15:0] tmr,
	input wire logic go,
	input wire logic ovf,
	input wire logic rise,
	input wire logic fall,
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	output logic evt,
	output logic [15:0] val_q,
	output logic irq_q,
	output logic pin_q,
	output logic oe_q
);
	logic cap;
	logic once;
	logic match;
	logic hit;
	logic blk_q;

	// ------------------------------------------------------------
	// Event detection
	// ------------------------------------------------------------
	always_comb begin
		cap = ((mode == ccc_pkg::CAP_RISE) && rise) || // R04
			((mode == ccc_pkg::CAP_FALL) && fall) ||
			((mode == ccc_pkg::CAP_BOTH) && (rise || fall));
		once = (mode == ccc_pkg::CMP_ONCE) || (mode == ccc_pkg::CMP_SET);
		match = mode[2] && go && (tmr == val_q); // R13 R15 R16
		hit = match && !(once && blk_q && !ovf); // R22
		evt = cap || hit; // R03
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			blk_q <= 1'b0;
		end else if (hit && once) begin
			blk_q <= 1'b1; // R07 R08 R22
		end else if (ovf || !once) begin
			blk_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Value register and request pulse
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			val_q <= ccc_pkg::WORD_ZERO;
		end else if (cap) begin
			val_q <= tmr; // R11
		end else if (wr_en) begin
			val_q <= wr_data; // R03
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= evt; // R05 R25
		end
	end

	// ------------------------------------------------------------
	// Pin output
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pin_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			oe_q <= (mode == ccc_pkg::CMP_TOG) ||
				(mode == ccc_pkg::CMP_SET); // R14
			if ((mode == ccc_pkg::CMP_TOG) && hit) begin
				pin_q <= !pin_q; // R06
			end else if (mode == ccc_pkg::CMP_SET) begin
				if (hit && !ovf) begin
					pin_q <= 1'b1; // R08
				end else if (ovf && !hit) begin
					pin_q <= 1'b0; // R08 R23
				end
			end
		end
	end
endmodule // ccc_chan
`default_nettype wire

// ===== rtl/ccc_pkg.sv
// Purpose: Shared constants for the capture/compare channel group
// Assumes: 16-bit register port, four channels per mode register
// Notes:   Offsets are byte addresses on the plain register port
package ccc_pkg;
	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int NCH = 4;
	localparam int DW = 16;
	localparam int FLD_W = 4;
	localparam int SEL_POS = 3;
	localparam int MODE_W = 3;
	localparam int STAG_MULT = 8;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_MODE = 16'hff28;
	localparam logic [15:0] ADDR_VAL0 = 16'hfe30;
	localparam logic [15:0] ADDR_STEP = 16'h0002;
	localparam logic [15:0] ADDR_TMR0 = 16'hfe50;
	localparam logic [15:0] ADDR_TMR1 = 16'hfe52;
	localparam logic [15:0] ADDR_REL0 = 16'hfe54;
	localparam logic [15:0] ADDR_REL1 = 16'hfe56;
	localparam logic [15:0] ADDR_CTRL = 16'hfe58;
	localparam logic [15:0] ADDR_STAT = 16'hfe5a;
	// ------------------------------------------------------------
	// Reset values and fields
	// ------------------------------------------------------------
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [15:0] TMR_MAX = 16'hffff;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam int CTRL_RUN0 = 0;
	localparam int CTRL_RUN1 = 1;
	localparam int CTRL_STAG = 2;
	localparam int CTRL_ADC = 3;
	// ------------------------------------------------------------
	// Channel mode codes
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] CAP_RISE = 3'h1;
	localparam logic [2:0] CAP_FALL = 3'h2;
	localparam logic [2:0] CAP_BOTH = 3'h3;
	localparam logic [2:0] CMP_IRQ = 3'h4;
	localparam logic [2:0] CMP_TOG = 3'h5;
	localparam logic [2:0] CMP_ONCE = 3'h6;
	localparam logic [2:0] CMP_SET = 3'h7;
endpackage

// ===== testbench/capture_compare_channel_bench.sv
// Purpose: Self-checking bench for the capture/compare channels
// Assumes: Timer period of 16 ticks from reload value fff0
// Notes:   Event counts are taken over whole timer periods
`timescale 1ns/1ps
`default_nettype none
module capture_compare_channel_bench;
	typedef struct {
		int ch;
		logic [15:0] mode;
		logic [15:0] val;
		int req;
		int rise;
		int fall;
		int adc;
		logic oe;
	} ccc_row_t;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic [3:0] pin_i;
	logic [3:0] pin_o;
	logic [3:0] pin_oe;
	logic [3:0] irq;
	logic adc;
	logic [3:0] prev_q = 4'h0;
	logic [15:0] got;
	int mismatches = 0;
	int tests_run = 0;
	int req_cnt [4];
	int rise_cnt [4];
	int fall_cnt [4];
	int adc_cnt = 0;
	int k;
	int r0;
	int u0;
	int f0;
	int a0;
	ccc_row_t rows [8] = '{
		'{0, 16'h0000, 16'hfff8, 0, 0, 0, 0, 1'b0},
		'{0, 16'h0004, 16'hfff8, 4, 0, 0, 0, 1'b0},
		'{0, 16'h0005, 16'hfff8, 4, 2, 2, 0, 1'b1},
		'{0, 16'h0006, 16'hfff8, 4, 0, 0, 0, 1'b0},
		'{0, 16'h0007, 16'hfff8, 4, 4, 4, 0, 1'b1},
		'{0, 16'h0007, 16'hfff0, 4, 0, 0, 0, 1'b1},
		'{0, 16'h000c, 16'hfff8, 0, 0, 0, 0, 1'b0},
		'{3, 16'h4000, 16'hfff8, 4, 0, 0, 4, 1'b0}
	};
	// ------------------------------------------------------------
	// Design, far side and clock
	// ------------------------------------------------------------
	capture_compare_channel #(.PRESCALE(1), .BANK_HI(1'b1)) u_dut (
		.sys_clk(sys_clk),
		.reset(reset),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.channel_pin_i(pin_i),
		.channel_pin_o(pin_o),
		.channel_pin_oe(pin_oe),
		.channel_interrupt_request(irq),
		.adc_trigger(adc)
	);
	ccc_far_end u_far (
		.sys_clk(sys_clk),
		.pin_o(pin_o),
		.pin_oe(pin_oe),
		.pin_i(pin_i)
	);
	always #10 sys_clk = ~sys_clk;
	// Event and pin edge counters
	always @(posedge sys_clk) begin
		for (int n = 0; n < 4; n++) begin
			if (irq[n] === 1'b1) req_cnt[n]++;
			if (pin_o[n] === 1'b1 && prev_q[n] === 1'b0) rise_cnt[n]++;
			if (pin_o[n] === 1'b0 && prev_q[n] === 1'b1) fall_cnt[n]++;
		end
		if (adc === 1'b1) adc_cnt++;
		prev_q <= pin_o;
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin
			mismatches++;
			$display("Error at %0t: seen %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// Write, then read straight after with no idle cycle
	task automatic reg_wr_rd(input logic [15:0] a, input logic [15:0] v,
		output logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		reg_rd(ccc_pkg::ADDR_MODE, got);
		check(got, ccc_pkg::MODE_RST);
		check({12'h000, irq}, 16'h0000);
		reg_wr_rd(ccc_pkg::ADDR_MODE, 16'ha5c3, got);
		check(got, 16'ha5c3);
		repeat (10) @(posedge sys_clk);
		check(16'(req_cnt[0] + req_cnt[1] + req_cnt[2]), 16'h0000);
		reg_rd(16'h0100, got);
		check(got, 16'h0000);
		reg_wr(ccc_pkg::ADDR_MODE, 16'h0000);
		reg_wr(ccc_pkg::ADDR_VAL0, 16'h1234);
		reg_rd(ccc_pkg::ADDR_VAL0, got);
		check(got, 16'h1234);
		// Timer 0 cycles fff0..ffff
		reg_wr(ccc_pkg::ADDR_REL0, 16'hfff0);
		reg_wr(ccc_pkg::ADDR_REL1, 16'hfff0);
		reg_wr(ccc_pkg::ADDR_TMR0, 16'hfff0);
		reg_wr(ccc_pkg::ADDR_CTRL, 16'h0009);
		foreach (rows[i]) begin
			k = rows[i].ch;
			reg_wr(ccc_pkg::ADDR_MODE, rows[i].mode);
			reg_wr(ccc_pkg::ADDR_VAL0 + 16'(2 * k), rows[i].val);
			repeat (32) @(posedge sys_clk);
			#1;
			r0 = req_cnt[k];
			u0 = rise_cnt[k];
			f0 = fall_cnt[k];
			a0 = adc_cnt;
			repeat (64) @(posedge sys_clk);
			#1;
			check(16'(req_cnt[k] - r0), 16'(rows[i].req));
			check(16'(rise_cnt[k] - u0), 16'(rows[i].rise));
			check(16'(fall_cnt[k] - f0), 16'(rows[i].fall));
			check(16'(adc_cnt - a0), 16'(rows[i].adc));
			check({15'h0000, pin_oe[k]}, {15'h0000, rows[i].oe});
		end
		// Running timer: software write of the timer to the value gives no match
		reg_wr(ccc_pkg::ADDR_VAL0, 16'h0500);
		reg_wr(ccc_pkg::ADDR_MODE, 16'h0004);
		r0 = req_cnt[0];
		reg_wr(ccc_pkg::ADDR_TMR0, 16'h0500);
		repeat (10) @(posedge sys_clk);
		check(16'(req_cnt[0] - r0), 16'h0000);
		reg_wr(ccc_pkg::ADDR_CTRL, 16'h0000);
		// Capture on each edge choice, channel 1
		for (int m = 1; m < 4; m++) begin
			reg_wr(ccc_pkg::ADDR_TMR0, 16'h1230 + 16'(m));
			reg_wr(ccc_pkg::ADDR_MODE, 16'(m << 4));
			r0 = req_cnt[1];
			u_far.drive(1, 1'b1);
			u_far.drive(1, 1'b0);
			check(16'(req_cnt[1] - r0), (m == 3) ? 16'h0002 : 16'h0001);
			reg_rd(ccc_pkg::ADDR_VAL0 + 16'h0002, got);
			check(got, 16'h1230 + 16'(m));
		end
		// Staggered slots: shared value, one channel per cycle
		reg_wr(ccc_pkg::ADDR_TMR0, 16'hfff0);
		reg_wr(ccc_pkg::ADDR_MODE, 16'h4444);
		for (int c = 0; c < 4; c++) begin
			reg_wr(ccc_pkg::ADDR_VAL0 + 16'(2 * c), 16'hfff8);
		end
		reg_rd(ccc_pkg::ADDR_STAT, got);
		check({12'h000, got[7:4]}, 16'h000f);
		reg_wr(ccc_pkg::ADDR_CTRL, 16'h0005);
		for (int c = 0; c < 200 && irq[0] !== 1'b1; c++) begin
			@(posedge sys_clk);
			#1;
		end
		for (int c = 0; c < 4; c++) begin
			check({12'h000, irq}, 16'h0001 << c);
			@(posedge sys_clk);
			#1;
		end
		// Second reset in mid-run
		reg_wr(ccc_pkg::ADDR_MODE, 16'h7777);
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		reg_rd(ccc_pkg::ADDR_MODE, got);
		check(got, 16'h0000);
		check({12'h000, pin_oe}, 16'h0000);
		close_out();
	end
	// Hang guard, about twenty times the expected run
	initial begin
		#400000;
		mismatches++;
		close_out();
	end
endmodule // capture_compare_channel_bench
`default_nettype wire

// ===== testbench/ccc_far_end.sv
// Purpose: Far-side model of the four channel pins
// Assumes: Pins rest low until the bench drives them
// Notes:   A pin the device drives reads back the device's output
`timescale 1ns/1ps
`default_nettype none
module ccc_far_end #(
	parameter int HOLD = 6
) (
	input wire logic sys_clk,
	input wire logic [3:0] pin_o,
	input wire logic [3:0] pin_oe,
	output logic [3:0] pin_i
);
	logic [3:0] lvl_q = 4'h0;
	// ------------------------------------------------------------
	// Wire level from both drivers
	// ------------------------------------------------------------
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & lvl_q);
	// Level change, then held stable
	task automatic drive(input int ch, input logic v);
		@(posedge sys_clk);
		lvl_q[ch] <= v;
		repeat (HOLD) @(posedge sys_clk);
	endtask
endmodule // ccc_far_end
`default_nettype wire
